// [hdl/bstap_regs.svh]
// constants for the boundary-scan test access block
`ifndef BSTAP_REGS_SVH
`define BSTAP_REGS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BSTAP_CTRL_OFS 8'h00
`define BSTAP_STATUS_OFS 8'h04
`define BSTAP_CHAIN_LO_OFS 8'h08
`define BSTAP_CHAIN_HI_OFS 8'h0c
`define BSTAP_CTRL_RST 32'h0000_0000
`define BSTAP_CTRL_FORCE_BIT 0
// ----------------------------------------
// instruction and chain constants
// ----------------------------------------
`define BSTAP_IR_W 8
`define BSTAP_IR_RESET 8'h81
`define BSTAP_IR_CAPTURE 8'h81
`define BSTAP_OP_EXTEST 8'h00
`define BSTAP_OP_IDCODE 8'h81
`define BSTAP_OP_SAMPLE 8'h82
`define BSTAP_OP_HIGHZ 8'h06
`define BSTAP_OP_CLAMP 8'h87
`define BSTAP_CHAIN_W 52
`define BSTAP_PINS_W 48
`define BSTAP_DRV_HI 51
`define BSTAP_DRV_LO 48
`define BSTAP_ID_W 32
// arbitrary identity value, names no real part
`define BSTAP_ID_VALUE 32'h0000_0001
`endif

// [hdl/bstap_pkg.sv]
// types for the boundary-scan test access block
package bstap_pkg;
  // ----------------------------------------
  // test controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
    ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
    ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
  } bstap_state_t;
  // decoded operations
  typedef enum logic [2:0] {
    OP_EXTEST = 3'h0, OP_IDCODE = 3'h1, OP_SAMPLE = 3'h2,
    OP_BYPASS = 3'h3, OP_HIGHZ = 3'h4, OP_CLAMP = 3'h5
  } bstap_op_t;
  // data register in the scan path
  typedef enum logic [1:0] {
    DR_BOUND = 2'h0, DR_BYPASS = 2'h1, DR_IDENT = 2'h2
  } bstap_dr_t;
  // transceiver pins in chain order, cells 47 down to 0
  typedef struct packed {
    logic grp2_direction;
    logic grp1_direction;
    logic grp2_output_enable_n;
    logic grp1_output_enable_n;
    logic grp2_a_to_b_clock;
    logic grp1_a_to_b_clock;
    logic grp2_b_to_a_clock;
    logic grp1_b_to_a_clock;
    logic grp2_a_to_b_select;
    logic grp1_a_to_b_select;
    logic grp2_b_to_a_select;
    logic grp1_b_to_a_select;
    logic [8:0] a2;
    logic [8:0] a1;
    logic [8:0] b2;
    logic [8:0] b1;
  } bstap_pins_t;
  // test drive towards the transceiver pads
  typedef struct packed {
    logic test_mode;
    logic grp2_b_drive_cell;
    logic grp1_b_drive_cell;
    logic grp2_a_drive_cell;
    logic grp1_a_drive_cell;
    logic [47:0] value;
  } bstap_drive_t;
endpackage

// [hdl/bstap_top.sv]
// boundary-scan test access port with instruction register and boundary chain
`timescale 1ns/10ps
`include "bstap_regs.svh"
module bstap_top (
  // system clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  // transceiver pins seen and driven by the chain
  input wire bstap_pkg::bstap_pins_t pins_in,
  output bstap_pkg::bstap_drive_t drive
);
  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // next controller state from mode-select
  function automatic bstap_pkg::bstap_state_t next_state(
    input bstap_pkg::bstap_state_t s, input logic m);
    case (s)
      bstap_pkg::ST_RESET: next_state = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_IDLE: next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_DR: next_state = m ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
      bstap_pkg::ST_CAP_DR: next_state = m ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_SH_DR: next_state = m ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_EX1_DR: next_state = m ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PA_DR;
      bstap_pkg::ST_PA_DR: next_state = m ? bstap_pkg::ST_EX2_DR : bstap_pkg::ST_PA_DR;
      bstap_pkg::ST_EX2_DR: next_state = m ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_UPD_DR: next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      bstap_pkg::ST_SEL_IR: next_state = m ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAP_IR;
      bstap_pkg::ST_CAP_IR: next_state = m ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_SH_IR: next_state = m ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_EX1_IR: next_state = m ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PA_IR;
      bstap_pkg::ST_PA_IR: next_state = m ? bstap_pkg::ST_EX2_IR : bstap_pkg::ST_PA_IR;
      bstap_pkg::ST_EX2_IR: next_state = m ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_UPD_IR: next_state = m ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
      default: next_state = bstap_pkg::ST_RESET;
    endcase
  endfunction

  // opcode decode; bad parity or unknown code acts as bypass
  function automatic bstap_pkg::bstap_op_t decode(input logic [7:0] ir);
    if (^ir) begin
      decode = bstap_pkg::OP_BYPASS;
    end else begin
      case (ir)
        `BSTAP_OP_EXTEST: decode = bstap_pkg::OP_EXTEST;
        `BSTAP_OP_IDCODE: decode = bstap_pkg::OP_IDCODE;
        `BSTAP_OP_SAMPLE: decode = bstap_pkg::OP_SAMPLE;
        `BSTAP_OP_HIGHZ: decode = bstap_pkg::OP_HIGHZ;
        `BSTAP_OP_CLAMP: decode = bstap_pkg::OP_CLAMP;
        default: decode = bstap_pkg::OP_BYPASS;
      endcase
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2, tdi_s1, tdi_s2;
  bstap_pkg::bstap_pins_t pins_s1, pins_s2;
  logic rise, fall;
  bstap_pkg::bstap_state_t state;
  logic [7:0] ir_sh;
  logic [7:0] instr;
  bstap_pkg::bstap_op_t op;
  bstap_pkg::bstap_dr_t dr_sel;
  logic bound_sel;
  logic [51:0] chain_sh;
  logic [51:0] chain_q;
  logic [51:0] chain_cap;
  logic bypass_sh;
  logic [31:0] id_sh;
  logic dr_lsb;
  logic force_reset;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic acc;

  // ----------------------------------------
  // synchronisers and test clock edges
  // ----------------------------------------
  // two flops on every pin before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      tck_s1 <= tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi;
      tdi_s2 <= tdi_s1;
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
    end
  end

  // edge pulses, one hclk cycle each
  assign rise = tck_s2 & ~tck_s3;
  assign fall = ~tck_s2 & tck_s3;

  // ----------------------------------------
  // test controller
  // ----------------------------------------
  // advances on rising edges; software may hold it in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bstap_pkg::ST_RESET;
    end else if (force_reset) begin
      state <= bstap_pkg::ST_RESET;
    end else if (rise) begin
      state <= next_state(state, tms_s2);
    end
  end

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  // shift stage: capture, shift, hold in pause and exits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_sh <= `BSTAP_IR_CAPTURE;
    end else if (rise) begin
      if (state == bstap_pkg::ST_CAP_IR) begin
        ir_sh <= `BSTAP_IR_CAPTURE;
      end else if (state == bstap_pkg::ST_SH_IR) begin
        ir_sh <= {tdi_s2, ir_sh[7:1]};
      end
    end
  end

  // instruction latches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= `BSTAP_IR_RESET;
    end else if (state == bstap_pkg::ST_RESET) begin
      instr <= `BSTAP_IR_RESET;
    end else if (fall && state == bstap_pkg::ST_UPD_IR) begin
      instr <= ir_sh;
    end
  end

  // decoded instruction picks register and source
  assign op = decode(instr);
  always_comb begin
    case (op)
      bstap_pkg::OP_EXTEST: dr_sel = bstap_pkg::DR_BOUND;
      bstap_pkg::OP_SAMPLE: dr_sel = bstap_pkg::DR_BOUND;
      bstap_pkg::OP_IDCODE: dr_sel = bstap_pkg::DR_IDENT;
      default: dr_sel = bstap_pkg::DR_BYPASS;
    endcase
  end
  assign bound_sel = (dr_sel == bstap_pkg::DR_BOUND);

  // ----------------------------------------
  // boundary chain
  // ----------------------------------------
  // capture value: drive cells from equations, then pins
  always_comb begin
    chain_cap = {1'b0, 1'b0, 1'b0, 1'b0, pins_s2};
    chain_cap[51] = ~pins_s2.grp2_output_enable_n & pins_s2.grp2_direction;
    chain_cap[50] = ~pins_s2.grp1_output_enable_n & pins_s2.grp1_direction;
    chain_cap[49] = ~pins_s2.grp2_output_enable_n & ~pins_s2.grp2_direction;
    chain_cap[48] = ~pins_s2.grp1_output_enable_n & ~pins_s2.grp1_direction;
  end

  // shift stage of the 52 cells
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_sh <= '0;
    end else if (state == bstap_pkg::ST_RESET) begin
      chain_sh[51:48] <= 4'h0;
    end else if (rise && bound_sel) begin
      if (state == bstap_pkg::ST_CAP_DR) begin
        chain_sh <= chain_cap;
      end else if (state == bstap_pkg::ST_SH_DR) begin
        chain_sh <= {tdi_s2, chain_sh[51:1]};
      end
    end
  end

  // hold latches of the chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chain_q <= '0;
    end else if (state == bstap_pkg::ST_RESET) begin
      chain_q[51:48] <= 4'h0;
    end else if (fall && state == bstap_pkg::ST_UPD_DR && bound_sel) begin
      chain_q <= chain_sh;
    end
  end

  // ----------------------------------------
  // bypass and identity shift stages
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bypass_sh <= 1'b0;
      id_sh <= `BSTAP_ID_VALUE;
    end else if (rise) begin
      if (state == bstap_pkg::ST_CAP_DR) begin
        bypass_sh <= 1'b0;
        id_sh <= `BSTAP_ID_VALUE;
      end else if (state == bstap_pkg::ST_SH_DR) begin
        bypass_sh <= tdi_s2;
        id_sh <= {tdi_s2, id_sh[31:1]};
      end
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  always_comb begin
    case (dr_sel)
      bstap_pkg::DR_BOUND: dr_lsb = chain_sh[0];
      bstap_pkg::DR_IDENT: dr_lsb = id_sh[0];
      default: dr_lsb = bypass_sh;
    endcase
  end

  // changes only on falling edges; floats outside shift states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (fall) begin
      if (state == bstap_pkg::ST_SH_IR) begin
        tdo_out <= ir_sh[0];
        tdo_oe <= 1'b1;
      end else if (state == bstap_pkg::ST_SH_DR) begin
        tdo_out <= dr_lsb;
        tdo_oe <= 1'b1;
      end else begin
        tdo_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // test drive to the pads
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive <= '0;
    end else begin
      drive.value <= chain_q[47:0];
      drive.test_mode <= (op == bstap_pkg::OP_EXTEST) || (op == bstap_pkg::OP_CLAMP)
                         || (op == bstap_pkg::OP_HIGHZ);
      if (op == bstap_pkg::OP_EXTEST || op == bstap_pkg::OP_CLAMP) begin
        drive.grp2_b_drive_cell <= chain_q[51];
        drive.grp1_b_drive_cell <= chain_q[50];
        drive.grp2_a_drive_cell <= chain_q[49];
        drive.grp1_a_drive_cell <= chain_q[48];
      end else begin
        drive.grp2_b_drive_cell <= 1'b0;
        drive.grp1_b_drive_cell <= 1'b0;
        drive.grp2_a_drive_cell <= 1'b0;
        drive.grp1_a_drive_cell <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // ahb-lite register slave
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready;

  // write address held into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= acc && hwrite;
      wr_addr <= haddr;
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_reset <= 1'b0;
    end else if (wr_pend && wr_addr == `BSTAP_CTRL_OFS) begin
      force_reset <= hwdata[`BSTAP_CTRL_FORCE_BIT];
    end
  end

  // read data captured in the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      case (haddr)
        `BSTAP_CTRL_OFS: hrdata <= {31'h0000_0000, force_reset};
        `BSTAP_STATUS_OFS: hrdata <= {14'h0000, tdo_oe, drive.test_mode, instr, 4'h0, state};
        `BSTAP_CHAIN_LO_OFS: hrdata <= chain_q[31:0];
        `BSTAP_CHAIN_HI_OFS: hrdata <= {12'h000, chain_q[51:32]};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ir_upd_fall;
    fall && state == bstap_pkg::ST_UPD_IR && !force_reset;
  endsequence
  sequence s_dr_upd_fall;
    fall && state == bstap_pkg::ST_UPD_DR && bound_sel && !force_reset;
  endsequence

  chk_tdo_float_dr: assert property (
    fall && state == bstap_pkg::ST_EX1_DR |=> !tdo_oe)
    else $error("serial output still driven in first data exit");
  chk_tdo_float_ir: assert property (
    fall && state == bstap_pkg::ST_EX1_IR |=> !tdo_oe)
    else $error("serial output still driven in first instruction exit");
  chk_ir_capture: assert property (
    rise && state == bstap_pkg::ST_CAP_IR && !force_reset |=> ir_sh == `BSTAP_IR_CAPTURE)
    else $error("instruction capture value wrong");
  chk_ir_tdo_lsb: assert property (
    fall && state == bstap_pkg::ST_SH_IR |=> tdo_oe && tdo_out == $past(ir_sh[0]))
    else $error("serial output not instruction lsb");
  chk_ir_shift_step: assert property (
    rise && state == bstap_pkg::ST_SH_IR |=> ir_sh == {$past(tdi_s2), $past(ir_sh[7:1])})
    else $error("instruction shift wrong");
  chk_ir_pause_hold: assert property (
    state == bstap_pkg::ST_PA_IR |=> $stable(ir_sh))
    else $error("instruction contents lost in pause");
  chk_ir_update_load: assert property (
    s_ir_upd_fall |=> instr == $past(ir_sh) ##1 op == decode($past(ir_sh, 2)))
    else $error("instruction latches not updated");
  chk_chain_update: assert property (
    s_dr_upd_fall |=> chain_q == $past(chain_sh))
    else $error("chain latches not updated");
  chk_reset_values: assert property (
    state == bstap_pkg::ST_RESET |=> instr == `BSTAP_IR_RESET && chain_q[51:48] == 4'h0)
    else $error("reset values not applied");
  chk_drive_capture: assert property (
    rise && state == bstap_pkg::ST_CAP_DR && bound_sel && !force_reset
    |=> chain_sh[48] == ($past(~pins_s2.grp1_output_enable_n & ~pins_s2.grp1_direction)))
    else $error("drive cell capture wrong");
endmodule

// [bench/bstap_ctl_model.sv]
// test-bus controller model that drives the four-wire test port
`timescale 1ns/10ps
module bstap_ctl_model (
  // test clock, mode select and serial data towards the device
  output logic tck,
  output logic tms,
  output logic tdi,
  // serial output and its enable from the device
  input wire logic tdo_out,
  input wire logic tdo_oe
);
  // serial output as seen on the wire, floating when not enabled
  wire tdo = tdo_oe ? tdo_out : 1'bz;

  // test clock stands low between frames, tdi idles high like a pull-up
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one test clock: levels set after the fall, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tms = m;
    tdi = d;
    #24;
    o = tdo;
    e = tdo_oe;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask

  // one controller transition with no data of interest
  task automatic move(input logic m);
    logic o;
    logic e;
    step(m, 1'b1, o, e);
  endtask

  // full scan from idle back to idle, lsb first, optional pause after bit brk
  task automatic scan(input logic is_ir, input int n, input int brk, input logic [63:0] din,
                      output logic [63:0] dout, output int oe_err);
    logic o;
    logic e;
    oe_err = 0;
    dout = '0;
    move(1'b1);
    if (is_ir) begin
      move(1'b1);
    end
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == brk, din[i], o, e);
      dout[i] = o;
      if (e !== 1'b1) oe_err++;
      // exit1, pause twice, exit2, then back to shifting without recapture
      if (i == brk && i != n - 1) begin
        step(1'b0, 1'b1, o, e);
        if (e !== 1'b0) oe_err++;
        step(1'b0, 1'b1, o, e);
        step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
      end
    end
    step(1'b1, 1'b1, o, e);
    if (e !== 1'b0) oe_err++;
    move(1'b0);
  endtask
endmodule

// [bench/tb.sv]
// self-checking testbench for the boundary-scan test access block
`timescale 1ns/10ps
`include "bstap_regs.svh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire hready;
  wire [31:0] hrdata;
  wire hresp;
  wire tck;
  wire tms;
  wire tdi;
  wire tdo_out;
  wire tdo_oe;
  bstap_pkg::bstap_pins_t pins_in = 48'h8c3a_5f09_e17b;
  bstap_pkg::bstap_drive_t drive;
  int miscompares = 0;
  int n_checks = 0;
  logic [63:0] dout;
  logic [31:0] rd;
  int oe_err;
  logic [51:0] pre = 52'h6_1234_5678_9abc;
  logic [7:0] ops [3] = '{8'h00, 8'h06, 8'h87};
  logic [4:0] ops_drv [3] = '{5'h16, 5'h10, 5'h16};
  logic [7:0] byp [3] = '{8'h03, 8'h01, 8'h84};

  // ----------------------------------------
  // clock, design and far-side model
  // ----------------------------------------
  // 200 mhz system clock
  always #2.5 hclk = ~hclk;

  bstap_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
    .tdo_oe(tdo_oe), .pins_in(pins_in), .drive(drive));

  bstap_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // value comparison, counted
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single ahb-lite word transfer, waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // verdict and end of run
  task automatic final_report;
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  // reset, then scans that walk the instruction and data paths
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    cmp(drive, 64'h0);
    ahb(1'b0, `BSTAP_STATUS_OFS, 32'h0, rd);
    cmp(rd[15:0], 16'h8100);
    ahb(1'b0, 8'h10, 32'h0, rd);
    cmp(rd, 32'h0);
    cmp(hresp, 1'b0);
    u_ctl.move(1'b0);
    // identity read selected out of reset
    u_ctl.scan(1'b0, 32, -1, 64'h0, dout, oe_err);
    cmp(dout[31:0], `BSTAP_ID_VALUE);
    cmp(oe_err, 0);
    // sample/preload, paused mid-scan
    u_ctl.scan(1'b1, 8, 3, 64'h82, dout, oe_err);
    cmp(dout[7:0], 8'h81);
    cmp(oe_err, 0);
    ahb(1'b0, `BSTAP_STATUS_OFS, 32'h0, rd);
    cmp(rd[15:8], 8'h82);
    u_ctl.scan(1'b0, 52, 20, {12'h0, pre}, dout, oe_err);
    cmp(dout[51:48], {~pins_in.grp2_output_enable_n & pins_in.grp2_direction,
      ~pins_in.grp1_output_enable_n & pins_in.grp1_direction,
      ~pins_in.grp2_output_enable_n & ~pins_in.grp2_direction,
      ~pins_in.grp1_output_enable_n & ~pins_in.grp1_direction});
    cmp(dout[47:0], pins_in);
    // normal mode: latches loaded, drive cells kept off the pads
    cmp(drive[52:48], 5'h00);
    cmp(drive[47:0], pre[47:0]);
    ahb(1'b0, `BSTAP_CHAIN_HI_OFS, 32'h0, rd);
    cmp(rd, {12'h000, pre[51:32]});
    // test-mode opcodes: extest and clamp drive cells from the latches, highz holds them at zero
    for (int i = 0; i < 3; i++) begin
      u_ctl.scan(1'b1, 8, -1, {56'h0, ops[i]}, dout, oe_err);
      cmp(drive[52:48], ops_drv[i]);
      cmp(drive[47:0], pre[47:0]);
    end
    // unimplemented or bad-parity opcodes give a one-bit path capturing 0
    for (int i = 0; i < 3; i++) begin
      u_ctl.scan(1'b1, 8, -1, {56'h0, byp[i]}, dout, oe_err);
      u_ctl.scan(1'b0, 8, -1, 64'ha5, dout, oe_err);
      cmp(dout[7:0], 8'h4a);
      cmp(drive[52], 1'b0);
    end
    // five tms highs reach test-logic-reset
    repeat (5) u_ctl.move(1'b1);
    ahb(1'b0, `BSTAP_STATUS_OFS, 32'h0, rd);
    cmp(rd[15:0], 16'h8100);
    u_ctl.move(1'b0);
    u_ctl.scan(1'b1, 8, -1, 64'h00, dout, oe_err);
    cmp(drive[52:48], 5'h10);
    // software force of the controller into reset
    ahb(1'b1, `BSTAP_CTRL_OFS, 32'h1, rd);
    ahb(1'b0, `BSTAP_CTRL_OFS, 32'h0, rd);
    cmp(rd, 32'h1);
    ahb(1'b0, `BSTAP_STATUS_OFS, 32'h0, rd);
    cmp(rd[15:0], 16'h8100);
    ahb(1'b1, `BSTAP_CTRL_OFS, 32'h0, rd);
    final_report();
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
